// *** rtl/tunnel_mode_command_handler.sv ***
// Contract
// [RULE1] start answer-wait timing right after the inquiry reply is fully sent
// [RULE2] pause timing from another host command's start until its reply ends
// [RULE3] reader read request uses 0x06 (JIS) or 0xB0 (Type B)
// [RULE4] reader write request uses 0x08 (JIS) or 0xD6 (Type B); the handler gives both an error reply
// [RULE5] host inquiry command is the single byte 0x28
// [RULE6] host result command 0xF8 means normal end, 0xE8 error
// [RULE7] JIS read: code, 8-byte id, k, 2k service bytes, m, block list
// [RULE8] service count outside 1..15 gives an error reply
// [RULE9] differing service identifiers give an error reply
// [RULE10] block count outside 1..15 gives an error reply
// [RULE11] Type B class byte other than 0x00 gives an error
// [RULE12] Type B P1 and P2 form the start address
// [RULE13] Type B length 1..251, multiple of 16 when encrypted
// [RULE14] encrypted length multiplier never above 15
// [RULE15] inquiry reply: status, address high, address low, length
// [RULE16] length byte gives bytes the reader wants from the host
// [RULE17] address upper byte bit7 is 0, bit6 is 1
// [RULE18] address upper bits 5:4 carry the security mode
// [RULE19] a host command starts when the slave address ack begins
// [RULE20] an error result carries only its code byte
// [RULE21] on timeout abandon the request and answer the reader with error
// [RULE22] timeout length is a parameter counted on the device clock
`timescale 1ns/10ps
module tunnel_mode_command_handler #(
	parameter int TMO_CYCLES = tunnel_pkg::ANSWER_WAIT_CYC,
	parameter logic [7:0] STATUS_OK = 8'h00 // arbitrary status code
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic rf_typeb_in,
	input wire logic [1:0] sec_mode_in,
	input wire logic rf_byte_valid_in,
	input wire logic [7:0] rf_byte_in,
	input wire logic rf_frame_end_in,
	input wire logic host_cmd_start_in,
	input wire logic host_byte_valid_in,
	input wire logic [7:0] host_byte_in,
	input wire logic host_cmd_end_in,
	input wire logic host_tx_ready_in,
	output logic host_irq_out,
	output logic host_tx_valid_out,
	output logic [7:0] host_tx_byte_out,
	output logic rf_data_valid_out,
	output logic [7:0] rf_data_out,
	output logic rf_done_out,
	output logic rf_error_out
);
	localparam int TMO_W = $clog2(TMO_CYCLES + 1);

	// ==================================================================
	// elaboration checks
	generate
		if (TMO_CYCLES < 1)
		begin : g_bad_tmo
			$error("timeout must be at least one cycle");
		end
	endgenerate

	typedef struct packed
	{
		tunnel_pkg::state_t st;
		tunnel_pkg::phase_t ph;
		logic [7:0] cnt;
		logic [7:0] svc_cnt;
		logic [15:0] svc_first;
		logic [7:0] svc_hi;
		logic [1:0] elem_left;
		logic first_elem;
		logic bad;
		logic [13:0] addr;
		logic [7:0] len;
		logic [1:0] mode;
		logic in_cmd;
		logic want_code;
		logic irq;
		logic [TMO_W-1:0] tmo;
		logic [1:0] tx_idx;
		tunnel_pkg::byte_t host_tx;
		tunnel_pkg::byte_t rf_data;
		logic rf_done;
		logic rf_err;
	} regs_t;

	regs_t r_reg;
	regs_t r_next;
	logic enc;

	// mode captured with the first byte, so a mid-frame change cannot skew the length check
	assign enc = r_reg.mode[1];

	// ==================================================================
	// next-state logic
	always_comb
	begin
		r_next = r_reg;
		r_next.rf_data.valid = 1'b0;
		r_next.rf_done = 1'b0;
		r_next.rf_err = 1'b0;
		// host command window, opened at the address ack
		if (host_cmd_start_in)
		begin
			r_next.in_cmd = 1'b1; // RULE19
			r_next.want_code = 1'b1;
		end
		if (host_byte_valid_in && r_reg.want_code)
			r_next.want_code = 1'b0;
		// a command with no bytes must not leave a stale code slot behind
		if (host_cmd_end_in)
		begin
			r_next.in_cmd = 1'b0;
			r_next.want_code = 1'b0;
		end
		// reply handshake: valid stands until ready
		if (r_reg.host_tx.valid && host_tx_ready_in)
			r_next.host_tx.valid = 1'b0;
		unique case (r_reg.st)
			tunnel_pkg::S_IDLE:
			begin
				if (rf_byte_valid_in)
				begin
					r_next.st = tunnel_pkg::S_RF;
					r_next.bad = 1'b0;
					r_next.first_elem = 1'b1;
					r_next.mode = sec_mode_in;
					r_next.addr = '0;
					r_next.cnt = 8'h01;
					r_next.ph = rf_typeb_in ? tunnel_pkg::P_B : tunnel_pkg::P_ID;
					if (rf_typeb_in)
						r_next.bad = 1'b0; // class checked below at index 0
					if (!rf_typeb_in && rf_byte_in != tunnel_pkg::JIS_READ_CODE) // RULE3
						r_next.bad = 1'b1; // write body not handled here: RULE4
					if (rf_typeb_in && rf_byte_in != tunnel_pkg::TYPEB_CLASS_OK)
						r_next.bad = 1'b1; // RULE11
				end
			end
			tunnel_pkg::S_RF:
			begin
				if (rf_byte_valid_in)
				begin
					r_next.cnt = r_reg.cnt + 8'h01;
					unique case (r_reg.ph)
						tunnel_pkg::P_ID:
						begin
							if (r_reg.cnt == {4'h0, tunnel_pkg::ID_BYTES}) // RULE7
								r_next.ph = tunnel_pkg::P_K;
						end
						tunnel_pkg::P_K:
						begin
							r_next.svc_cnt = {rf_byte_in[6:0], 1'b0};
							r_next.cnt = 8'h00;
							r_next.ph = tunnel_pkg::P_SVC;
							if (rf_byte_in < tunnel_pkg::COUNT_MIN || rf_byte_in > tunnel_pkg::COUNT_MAX)
							begin
								r_next.bad = 1'b1; // RULE8
								r_next.svc_cnt = 8'h00;
							end
						end
						tunnel_pkg::P_SVC:
						begin
							if (r_reg.cnt[0])
							begin
								// every identifier must equal the first one
								if (r_reg.cnt == 8'h01)
									r_next.svc_first = {rf_byte_in, r_reg.svc_hi};
								else if ({rf_byte_in, r_reg.svc_hi} != r_reg.svc_first)
									r_next.bad = 1'b1; // RULE9
							end
							else
								r_next.svc_hi = rf_byte_in;
							if (r_reg.cnt + 8'h01 >= r_reg.svc_cnt)
								r_next.ph = tunnel_pkg::P_M;
						end
						tunnel_pkg::P_M:
						begin
							r_next.len = {rf_byte_in[3:0], 4'h0}; // RULE16
							r_next.ph = tunnel_pkg::P_LIST;
							r_next.elem_left = 2'h0;
							if (rf_byte_in < tunnel_pkg::COUNT_MIN || rf_byte_in > tunnel_pkg::COUNT_MAX)
								r_next.bad = 1'b1; // RULE10
						end
						tunnel_pkg::P_LIST:
						begin
							// element head: bit 7 set means a two-byte element
							if (r_reg.elem_left == 2'h0)
								r_next.elem_left = rf_byte_in[7] ? 2'h1 : 2'h2;
							else
							begin
								r_next.elem_left = r_reg.elem_left - 2'h1;
								// only the byte right after the first head is the block number, whatever its top bit
								if (r_reg.first_elem)
									r_next.addr = 14'(rf_byte_in) << tunnel_pkg::BLOCK_SHIFT;
								r_next.first_elem = 1'b0;
							end
						end
						tunnel_pkg::P_B:
						begin
							unique case (r_reg.cnt[2:0])
								3'h1:
								begin
									if (rf_byte_in != tunnel_pkg::TYPEB_READ_INS) // RULE3
										r_next.bad = 1'b1; // write body not handled here: RULE4
								end
								3'h2: r_next.addr[13:8] = rf_byte_in[5:0]; // RULE12
								3'h3: r_next.addr[7:0] = rf_byte_in; // RULE12
								3'h4:
								begin
									r_next.len = rf_byte_in; // RULE16
									if (rf_byte_in < tunnel_pkg::COUNT_MIN || rf_byte_in > tunnel_pkg::LE_MAX)
										r_next.bad = 1'b1; // RULE13
									if (enc && (rf_byte_in[3:0] != 4'h0 || rf_byte_in > tunnel_pkg::ENC_LE_MAX))
										r_next.bad = 1'b1; // RULE13 RULE14
								end
								default: r_next.bad = 1'b1; // frame too long
							endcase
						end
						default: r_next.bad = 1'b1;
					endcase
				end
				if (rf_frame_end_in)
				begin
					// a short JIS frame never reached its count bytes; a short Type B frame stays in P_B and is not caught here
					if (r_next.bad || (r_reg.ph != tunnel_pkg::P_LIST && r_reg.ph != tunnel_pkg::P_B))
					begin
						r_next.st = tunnel_pkg::S_IDLE;
						r_next.rf_done = 1'b1;
						r_next.rf_err = 1'b1;
					end
					else
						r_next.st = tunnel_pkg::S_WAIT_INQ;
				end
			end
			tunnel_pkg::S_WAIT_INQ:
			begin
				if (host_byte_valid_in && r_reg.want_code && host_byte_in == tunnel_pkg::HOST_INQUIRY_CODE) // RULE5
				begin
					r_next.st = tunnel_pkg::S_INQ_TX;
					r_next.tx_idx = 2'h0;
					r_next.host_tx.valid = 1'b1;
					r_next.host_tx.data = STATUS_OK; // RULE15
				end
			end
			tunnel_pkg::S_INQ_TX:
			begin
				if (r_reg.host_tx.valid && host_tx_ready_in)
				begin
					r_next.tx_idx = r_reg.tx_idx + 2'h1;
					r_next.host_tx.valid = (r_reg.tx_idx != tunnel_pkg::INQ_LAST);
					unique case (r_reg.tx_idx)
						2'h0: r_next.host_tx.data = {tunnel_pkg::MARK_TUNNEL, r_reg.mode, r_reg.addr[11:8]}; // RULE17 RULE18
						2'h1: r_next.host_tx.data = r_reg.addr[7:0]; // RULE15
						2'h2: r_next.host_tx.data = r_reg.len; // RULE15 RULE16
						default: r_next.host_tx.data = r_reg.host_tx.data;
					endcase
					if (r_reg.tx_idx == tunnel_pkg::INQ_LAST)
					begin
						r_next.st = tunnel_pkg::S_WAIT_RES;
						r_next.tmo = '0; // RULE1
					end
				end
			end
			tunnel_pkg::S_WAIT_RES:
			begin
				// the clock stops while any other host command is open
				if (!r_reg.in_cmd) // RULE2
					r_next.tmo = r_reg.tmo + TMO_W'(1); // RULE22
				if (host_byte_valid_in && r_reg.want_code)
				begin
					if (host_byte_in == tunnel_pkg::RESULT_OK_CODE) // RULE6
					begin
						r_next.st = tunnel_pkg::S_RES_DATA;
					end
					else if (host_byte_in == tunnel_pkg::RESULT_ERR_CODE) // RULE6
					begin
						r_next.st = tunnel_pkg::S_RES_DATA; // RULE20
						r_next.bad = 1'b1;
					end
				end
				if (r_reg.tmo == TMO_W'(TMO_CYCLES) && !r_reg.in_cmd)
				begin
					r_next.st = tunnel_pkg::S_IDLE; // RULE21
					r_next.rf_done = 1'b1;
					r_next.rf_err = 1'b1;
				end
			end
			tunnel_pkg::S_RES_DATA:
			begin
				// data bytes pass straight through to the reader side
				if (host_byte_valid_in && !r_reg.bad)
				begin
					r_next.rf_data.valid = 1'b1;
					r_next.rf_data.data = host_byte_in;
				end
				if (host_cmd_end_in)
				begin
					r_next.st = tunnel_pkg::S_IDLE;
					r_next.host_tx.valid = 1'b1;
					r_next.host_tx.data = STATUS_OK;
					r_next.rf_done = 1'b1;
					r_next.rf_err = r_reg.bad; // RULE6
				end
			end
			default: r_next.st = tunnel_pkg::S_IDLE;
		endcase
		// request flag follows the next state, so the pin comes from its own flop
		r_next.irq = (r_next.st == tunnel_pkg::S_WAIT_INQ);
	end

	// ==================================================================
	// state register, frozen while the clock enable is low
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			r_reg <= '0;
		else if (ce_in)
			r_reg <= r_next;
	end

	// ==================================================================
	// outputs, all straight from the state register
	assign host_irq_out = r_reg.irq;
	assign host_tx_valid_out = r_reg.host_tx.valid;
	assign host_tx_byte_out = r_reg.host_tx.data;
	assign rf_data_valid_out = r_reg.rf_data.valid;
	assign rf_data_out = r_reg.rf_data.data;
	assign rf_done_out = r_reg.rf_done;
	assign rf_error_out = r_reg.rf_err;
endmodule // tunnel_mode_command_handler

// *** rtl/tunnel_pkg.sv ***
package tunnel_pkg;
	// ==================================================================
	// command codes
	localparam logic [7:0] JIS_READ_CODE = 8'h06;
	localparam logic [7:0] JIS_WRITE_CODE = 8'h08;
	localparam logic [7:0] TYPEB_READ_INS = 8'hB0;
	localparam logic [7:0] TYPEB_WRITE_INS = 8'hD6;
	localparam logic [7:0] TYPEB_CLASS_OK = 8'h00;
	localparam logic [7:0] HOST_INQUIRY_CODE = 8'h28;
	localparam logic [7:0] RESULT_OK_CODE = 8'hF8;
	localparam logic [7:0] RESULT_ERR_CODE = 8'hE8;
	// ==================================================================
	// parameter ranges and field layout
	localparam logic [7:0] COUNT_MIN = 8'h01;
	localparam logic [7:0] COUNT_MAX = 8'h0F;
	localparam logic [7:0] LE_MAX = 8'hFB;
	localparam logic [7:0] ENC_LE_MAX = 8'hF0;
	localparam logic [3:0] ID_BYTES = 4'h8;
	localparam logic [1:0] MARK_TUNNEL = 2'b01; // upper address bits 7:6
	localparam int BLOCK_SHIFT = 4; // 16-byte blocks
	localparam logic [1:0] INQ_LAST = 2'h3; // four reply bytes
	// ==================================================================
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int ANSWER_WAIT_US = 100000;
	localparam int ANSWER_WAIT_CYC = ANSWER_WAIT_US * 1000 / CLK_PERIOD_NS;

	typedef enum logic [2:0]
	{
		S_IDLE = 3'b000,
		S_RF = 3'b001,
		S_WAIT_INQ = 3'b010,
		S_INQ_TX = 3'b011,
		S_WAIT_RES = 3'b100,
		S_RES_DATA = 3'b101
	} state_t;

	typedef enum logic [2:0]
	{
		P_CODE = 3'b000,
		P_ID = 3'b001,
		P_K = 3'b010,
		P_SVC = 3'b011,
		P_M = 3'b100,
		P_LIST = 3'b101,
		P_B = 3'b110
	} phase_t;

	typedef struct packed
	{
		logic valid;
		logic [7:0] data;
	} byte_t;
endpackage

// *** bench/handler_properties.sv ***
`timescale 1ns/10ps
// ==========================================
// port checker for the tunnel command handler
module handler_properties #(
	parameter logic [7:0] STATUS_OK = 8'h00
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic rf_frame_end_in,
	input wire logic host_cmd_end_in,
	input wire logic host_byte_valid_in,
	input wire logic [7:0] host_byte_in,
	input wire logic host_tx_ready_in,
	input wire logic host_irq_out,
	input wire logic host_tx_valid_out,
	input wire logic [7:0] host_tx_byte_out,
	input wire logic rf_data_valid_out,
	input wire logic [7:0] rf_data_out,
	input wire logic rf_done_out,
	input wire logic rf_error_out
);
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic [2:0] idx_reg;
	sequence s_inquiry;
		ce_in && host_irq_out && host_byte_valid_in && host_byte_in == tunnel_pkg::HOST_INQUIRY_CODE;
	endsequence
	sequence s_status;
		host_tx_valid_out && host_tx_byte_out == STATUS_OK;
	endsequence
	// reply byte index, so the address byte can be picked out
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			idx_reg <= 3'h4;
		else if (ce_in && host_irq_out && host_byte_valid_in && host_byte_in == tunnel_pkg::HOST_INQUIRY_CODE)
			idx_reg <= 3'h0;
		else if (ce_in && host_tx_valid_out && host_tx_ready_in && idx_reg < 3'h4)
			idx_reg <= idx_reg + 3'h1;
	end
	AST_INQ_ANSWER: assert property (s_inquiry |=> s_status)
		else $error("no status after inquiry");
	AST_TX_HOLD: assert property (host_tx_valid_out && !host_tx_ready_in |=> host_tx_valid_out && $stable(host_tx_byte_out))
		else $error("reply byte dropped");
	AST_ADDR_MARK: assert property (host_tx_valid_out && idx_reg == 3'h1 |-> host_tx_byte_out[7:6] == 2'b01)
		else $error("tunnel mark missing");
	AST_IRQ_CAUSE: assert property ($rose(host_irq_out) |-> $past(rf_frame_end_in))
		else $error("request without frame");
	AST_DONE_PULSE: assert property (rf_done_out && ce_in |=> !rf_done_out)
		else $error("done not a pulse");
	AST_ERR_QUAL: assert property (rf_error_out |-> rf_done_out)
		else $error("error without done");
	AST_DONE_CAUSE: assert property ($rose(rf_done_out) && !rf_error_out |-> $past(host_cmd_end_in))
		else $error("good done without result");
	AST_DATA_NEXT: assert property (rf_data_valid_out && $past(ce_in) |->
		$past(host_byte_valid_in) && rf_data_out == $past(host_byte_in))
		else $error("relayed byte wrong");
endmodule // handler_properties

bind tunnel_mode_command_handler handler_properties #(.STATUS_OK(STATUS_OK)) props (.*);

// *** bench/host_model.sv ***
`timescale 1ns/10ps
// ==========================================
// host controller on the serial side
module host_model (
	input wire logic core_clk_in,
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_byte_in,
	output logic cmd_start_out,
	output logic byte_valid_out,
	output logic [7:0] byte_out,
	output logic cmd_end_out,
	output logic tx_ready_out
);
	// bus idle at time zero
	initial
	begin
		{cmd_start_out, byte_valid_out, byte_out, cmd_end_out, tx_ready_out} = '0;
	end
	// open at the address ack, then write the bytes; others pause the wait
	task automatic send_cmd(input logic [7:0] q[$]);
		@(posedge core_clk_in);
		cmd_start_out <= 1'b1;
		@(posedge core_clk_in);
		cmd_start_out <= 1'b0;
		foreach (q[i])
		begin
			byte_valid_out <= 1'b1;
			byte_out <= q[i];
			@(posedge core_clk_in);
		end
		byte_valid_out <= 1'b0;
		byte_out <= ~byte_out; // a released line never keeps the last byte
	endtask
	task automatic end_cmd;
		@(posedge core_clk_in);
		cmd_end_out <= 1'b1;
		@(posedge core_clk_in);
		cmd_end_out <= 1'b0;
	endtask
	// read reply bytes, stalling before each; first byte lands highest
	task automatic take(input int n, input int stall, output logic [31:0] got);
		int w;
		got = '0;
		for (int i = 0; i < n; i++)
		begin
			if (stall > 0)
				tx_ready_out <= 1'b0;
			repeat (stall) @(posedge core_clk_in);
			tx_ready_out <= 1'b1;
			for (w = 0; w <= 40 && (w == 0 || tx_valid_in !== 1'b1); w++) @(posedge core_clk_in);
			got = {got[23:0], (w <= 40) ? tx_byte_in : 8'hxx};
		end
		tx_ready_out <= 1'b0;
	endtask
endmodule // host_model

// *** bench/tunnel_mode_command_handler_test.sv ***
`timescale 1ns/10ps
module tunnel_mode_command_handler_test;
	localparam int TMO = 20;
	localparam logic [7:0] STATUS_OK = 8'h00;
	logic core_clk_in, rst_n_in, ce_in, rf_typeb_in, rf_byte_valid_in, rf_frame_end_in, last_err;
	logic host_cmd_start_in, host_byte_valid_in, host_cmd_end_in, host_tx_ready_in;
	logic host_irq_out, host_tx_valid_out, rf_data_valid_out, rf_done_out, rf_error_out;
	logic [1:0] sec_mode_in;
	logic [7:0] rf_byte_in, host_byte_in, host_tx_byte_out, rf_data_out;
	logic [7:0] data_q[$];
	logic [31:0] got;
	int errors, comparisons, dones, c;
	tunnel_mode_command_handler #(.TMO_CYCLES(TMO), .STATUS_OK(STATUS_OK)) dut (.*);
	host_model host (.core_clk_in(core_clk_in), .tx_valid_in(host_tx_valid_out), .tx_byte_in(host_tx_byte_out),
		.cmd_start_out(host_cmd_start_in), .byte_valid_out(host_byte_valid_in), .byte_out(host_byte_in),
		.cmd_end_out(host_cmd_end_in), .tx_ready_out(host_tx_ready_in));
	// ==========================================
	// clock, watchdog and reader-side tally
	initial
	begin
		core_clk_in = 1'b0;
		forever #10 core_clk_in = ~core_clk_in;
	end
	initial
	begin
		repeat (20000) @(posedge core_clk_in);
		errors++;
		test_done();
	end
	// frozen pulses are counted once, when the enable returns
	always @(posedge core_clk_in)
	begin
		if (rf_done_out === 1'b1 && ce_in === 1'b1)
			dones++;
		if (rf_done_out === 1'b1 && ce_in === 1'b1)
			last_err = rf_error_out;
		if (rf_data_valid_out === 1'b1 && ce_in === 1'b1)
			data_q.push_back(rf_data_out);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		if (seen !== exp)
			errors++;
	endtask
	task automatic test_done;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_done(input int max);
		int d0;
		d0 = dones;
		for (c = 0; c < max && dones == d0; c++) @(negedge core_clk_in);
		if (dones == d0)
			errors++;
		if (dones == d0)
			test_done();
	endtask
	task automatic wait_irq;
		int w;
		for (w = 0; w < 10 && host_irq_out !== 1'b1; w++) @(negedge core_clk_in);
		check(32'(host_irq_out), 32'h0000_0001);
		if (host_irq_out !== 1'b1)
			test_done();
	endtask
	// ==========================================
	// reader frames
	task automatic rf_send(input logic tb, input logic [1:0] md, input logic [7:0] q[$]);
		@(posedge core_clk_in);
		rf_typeb_in <= tb;
		sec_mode_in <= md;
		foreach (q[i])
		begin
			rf_byte_valid_in <= 1'b1;
			rf_byte_in <= q[i];
			@(posedge core_clk_in);
		end
		rf_byte_valid_in <= 1'b0;
		rf_byte_in <= ~rf_byte_in;
		rf_frame_end_in <= 1'b1;
		@(posedge core_clk_in);
		rf_frame_end_in <= 1'b0;
	endtask
	// code, id, k, 2k service bytes, m, two-byte block elements whose numbers have the top bit set
	task automatic jis(input logic [7:0] code, input logic [7:0] k, input logic [7:0] m, input logic diff);
		logic [7:0] q[$];
		q = {code};
		repeat (8) q.push_back(8'h11);
		q.push_back(k);
		for (int i = 0; i < k; i++)
			q = {q, 8'h09, (diff && i > 0) ? 8'h01 : 8'h00};
		q.push_back(m);
		for (int i = 0; i < m; i++)
			q = {q, 8'h80, 8'(8'h83 + i)};
		rf_send(1'b0, 2'b00, q);
	endtask
	task automatic expect_err;
		wait_done(6);
		check(32'({c <= 4, last_err, host_irq_out}), 32'h0000_0006);
	endtask
	task automatic bad_jis(input logic [7:0] code, input logic [7:0] k, input logic [7:0] m, input logic diff);
		jis(code, k, m, diff);
		expect_err();
	endtask
	task automatic bad_tb(input logic [1:0] md, input logic [7:0] cla, input logic [7:0] ins, input logic [7:0] le);
		rf_send(1'b1, md, {cla, ins, 8'h00, 8'h10, le});
		expect_err();
	endtask
	// ==========================================
	// scenarios
	task automatic s_errors;
		bad_jis(8'h06, 8'h00, 8'h01, 1'b0);
		bad_jis(8'h06, 8'h10, 8'h01, 1'b0);
		bad_jis(8'h06, 8'h03, 8'h01, 1'b1);
		bad_jis(8'h06, 8'h01, 8'h00, 1'b0);
		bad_jis(8'h06, 8'h01, 8'h10, 1'b0);
		bad_jis(8'h08, 8'h01, 8'h01, 1'b0);
		bad_tb(2'b00, 8'h01, 8'hB0, 8'h10);
		bad_tb(2'b00, 8'h00, 8'hD6, 8'h10);
		bad_tb(2'b00, 8'h00, 8'hB0, 8'h00);
		bad_tb(2'b00, 8'h00, 8'hB0, 8'hFC);
		bad_tb(2'b10, 8'h00, 8'hB0, 8'h18);
	endtask
	task automatic s_typeb_ok;
		int d0;
		data_q.delete();
		rf_send(1'b1, 2'b10, {8'h00, 8'hB0, 8'h05, 8'h3C, 8'h20});
		wait_irq();
		host.send_cmd({8'h28});
		host.take(4, 2, got);
		check(got, 32'h0065_3C20);
		host.end_cmd();
		d0 = dones;
		host.send_cmd({8'h10});
		repeat (2 * TMO) @(posedge core_clk_in);
		host.end_cmd();
		check(32'(dones), 32'(d0));
		host.send_cmd({8'hF8, 8'hA5, 8'h5A});
		host.end_cmd();
		wait_done(6);
		check({8'(data_q.size()), data_q[0], data_q[1], 7'h00, last_err}, 32'h02A5_5A00);
		host.take(1, 0, got);
		check(got, 32'(STATUS_OK));
	endtask
	task automatic s_jis_timeout;
		jis(8'h06, 8'h0F, 8'h0F, 1'b0);
		wait_irq();
		host.send_cmd({8'h28});
		host.take(4, 0, got);
		check(got, 32'h0048_30F0);
		host.end_cmd();
		ce_in <= 1'b0;
		repeat (5) @(posedge core_clk_in);
		ce_in <= 1'b1;
		wait_done(TMO + 10);
		check(32'({c >= TMO - 2, c <= TMO + 4, last_err}), 32'h0000_0007);
	endtask
	task automatic s_result_err;
		data_q.delete();
		rf_send(1'b1, 2'b11, {8'h00, 8'hB0, 8'h00, 8'h10, 8'h10});
		wait_irq();
		host.send_cmd({8'h28});
		host.take(4, 1, got);
		check(got, 32'h0070_1010);
		host.end_cmd();
		host.send_cmd({8'hE8});
		host.end_cmd();
		wait_done(6);
		check(32'({data_q.size() == 0, last_err}), 32'h0000_0003);
		host.take(1, 0, got);
		check(got, 32'(STATUS_OK));
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		{rst_n_in, rf_typeb_in, sec_mode_in, rf_byte_valid_in, rf_byte_in, rf_frame_end_in} = '0;
		ce_in = 1'b1;
		repeat (6) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		s_errors();
		s_typeb_ok();
		s_jis_timeout();
		s_result_err();
		test_done();
	end
endmodule // tunnel_mode_command_handler_test
